//--- shared/cfg_wr_map.vh
// constants for the two-wire configuration write target
// assumes: included by bare name from the design files under hw/
// Overview of operation
// - address byte: seven-bit target, bit0 zero writes
// - address pins all low answer to 68h
// - four command bytes follow, each acknowledged
// - command byte 0 bits 2:0, 011b writes
// - command byte 2 bits 5:2 are byte enables
// - command byte 2 bits 1:0 are address 11:10
// - command byte 3 is register address 9:2
// - four data bytes acknowledged, then STOP
// - first data byte lands in register byte 3
// - port select from byte1 3:0 and byte2 bit7
// - disabled bytes unchanged, enabled bytes updated
// - extra data bytes get a negative acknowledge
// - invalid command leaves register untouched
`ifndef CFG_WR_MAP_VH
`define CFG_WR_MAP_VH
`define TGT_ADDR_BASE 7'h68
`define OPC_WRITE 3'h3
`define OPC_LSB 0
`define BE_LSB 2
`define PORT_HI_LSB 0
`define PORT_LO_BIT 7
`define ADDR_HI_LSB 0
`define CMD_BYTES 3'h4
`define DATA_BYTES 3'h4
`define PORT_COUNT 5'h06
`endif

//--- hw/line_sync.v
// two-flop synchroniser plus edge detect for one link line
// assumes: line comes from outside the SYS_CLK domain
`default_nettype none
module line_sync (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire din,
  output wire lvl,
  output wire rise,
  output wire fall
);
  reg meta_ff; // first stage, read only by sync_ff
  reg sync_ff; // second stage
  reg last_ff; // previous synced level
  // sample the line, idle high
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else if (ce) begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign lvl = sync_ff;
  assign rise = ce & sync_ff & ~last_ff;
  assign fall = ce & ~sync_ff & last_ff;
endmodule // line_sync
`default_nettype wire

//--- hw/cfg_wr_target.v
// two-wire target that accepts configuration register writes
// assumes: controller drives the link clock; SDA open drain, pull-up outside
`include "cfg_wr_map.vh"
`default_nettype none
module cfg_wr_target (
  input wire SYS_CLK,
  input wire RESETN,
  input wire CE,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire [2:0] ADDR_SEL,
  output reg WR_STB,
  output reg [4:0] WR_PORT,
  output reg [11:0] WR_ADDR,
  output reg [3:0] WR_BE,
  output reg [31:0] WR_DATA
);
  // states, one-hot
  localparam ST_IDLE = 5'h01; // wait for START
  localparam ST_ADDR = 5'h02; // address byte
  localparam ST_CMD = 5'h04;  // command bytes
  localparam ST_DATA = 5'h08; // data bytes
  localparam ST_SKIP = 5'h10; // not ours or extra, ignore until frame end

  // synchronised link lines and their edges
  wire scl_lvl, scl_rise, scl_fall;
  wire sda_lvl, sda_rise, sda_fall;
  line_sync u_scl (
    .clk(SYS_CLK), .resetn(RESETN), .ce(CE), .din(SCL_IN),
    .lvl(scl_lvl), .rise(scl_rise), .fall(scl_fall)
  );
  line_sync u_sda (
    .clk(SYS_CLK), .resetn(RESETN), .ce(CE), .din(SDA_IN),
    .lvl(sda_lvl), .rise(sda_rise), .fall(sda_fall)
  );

  // frame marks: data moves while the clock is high
  wire start_ev = sda_fall & scl_lvl; // START or repeated START
  wire stop_ev = sda_rise & scl_lvl;  // STOP

  // packet sequencing state
  reg [4:0] state_ff;
  reg [7:0] shift_ff; // incoming byte
  reg [3:0] bit_ff;   // bits received, 8 then ack slot
  reg ack_slot_ff;    // in acknowledge clock
  reg ack_drv_ff;     // pulling SDA low
  reg nak_ff;         // this byte gets no acknowledge
  reg [2:0] cnt_ff;   // byte count within phase
  // command bytes kept for the write decode
  reg [7:0] cmd0_ff, cmd1_ff, cmd2_ff, cmd3_ff;
  reg [31:0] data_ff;
  reg full_ff;        // four data bytes received and acknowledged
  reg [2:0] sel_meta_ff; // address straps, first stage
  reg [2:0] sel_sync_ff; // address straps, second stage

  // bring the address straps into the clock domain
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // straps read as all low until sampled
      sel_meta_ff <= 3'h0;
      sel_sync_ff <= 3'h0;
    end else if (CE) begin
      // only the second stage is read by the decode
      sel_meta_ff <= ADDR_SEL;
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // which byte slot an incoming data byte lands in
  function [31:0] put_byte;
    input [31:0] word;
    input [2:0] idx;
    input [7:0] b;
    begin
      put_byte = word;
      case (idx)
        3'h0: put_byte[31:24] = b;
        3'h1: put_byte[23:16] = b;
        3'h2: put_byte[15:8] = b;
        default: put_byte[7:0] = b;
      endcase
    end
  endfunction

  // decoded fields of the address and command bytes
  wire [7:0] byte_in = {shift_ff[6:0], sda_lvl};
  wire [6:0] my_addr = `TGT_ADDR_BASE | {4'h0, sel_sync_ff};
  wire [4:0] port_sel = {cmd1_ff[`PORT_HI_LSB+3:`PORT_HI_LSB],
    cmd2_ff[`PORT_LO_BIT]};
  wire cmd_ok = (cmd0_ff[`OPC_LSB+2:`OPC_LSB] == `OPC_WRITE)
    && (port_sel < `PORT_COUNT);

  // receive, acknowledge and sequence the write packet
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // idle, no packet under way
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      ack_slot_ff <= 1'b0;
      ack_drv_ff <= 1'b0;
      nak_ff <= 1'b0;
      cnt_ff <= 3'h0;
      cmd0_ff <= 8'h00;
      cmd1_ff <= 8'h00;
      cmd2_ff <= 8'h00;
      cmd3_ff <= 8'h00;
      data_ff <= 32'h00000000;
      full_ff <= 1'b0;
    end else if (CE) begin
      // a low enable freezes the whole receiver
      if (start_ev) begin
        // new frame, drop any unfinished packet
        state_ff <= ST_ADDR;
        bit_ff <= 4'h0;
        ack_slot_ff <= 1'b0;
        ack_drv_ff <= 1'b0;
        full_ff <= 1'b0;
      end else if (stop_ev) begin
        // STOP closes the frame; a short packet is dropped
        state_ff <= ST_IDLE;
        ack_slot_ff <= 1'b0;
        ack_drv_ff <= 1'b0;
        full_ff <= 1'b0;
      end else if (state_ff != ST_IDLE && state_ff != ST_SKIP) begin
        // only a frame addressed to us is followed
        if (scl_rise && !ack_slot_ff) begin
          // sample a data bit
          shift_ff <= byte_in;
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == 4'h7) begin
            nak_ff <= 1'b0;
            case (state_ff)
              ST_ADDR: begin
                // target address and direction
                if (byte_in[7:1] != my_addr || byte_in[0]) begin
                  nak_ff <= 1'b1;
                end
                cnt_ff <= 3'h0;
              end
              ST_CMD: begin
                // command bytes land in order
                cnt_ff <= cnt_ff + 3'h1;
                case (cnt_ff)
                  3'h0: cmd0_ff <= byte_in;
                  3'h1: cmd1_ff <= byte_in;
                  3'h2: cmd2_ff <= byte_in;
                  default: cmd3_ff <= byte_in;
                endcase
              end
              ST_DATA: begin
                // data bytes, any beyond four refused
                if (cnt_ff == `DATA_BYTES) begin
                  nak_ff <= 1'b1;
                end else begin
                  data_ff <= put_byte(data_ff, cnt_ff, byte_in);
                  cnt_ff <= cnt_ff + 3'h1;
                end
              end
              default: begin
                // idle and skip never get here
                nak_ff <= 1'b1;
              end
            endcase
          end
        end else if (scl_fall && bit_ff == 4'h8 && !ack_slot_ff) begin
          // enter acknowledge clock
          ack_slot_ff <= 1'b1;
          ack_drv_ff <= ~nak_ff;
        end else if (scl_fall && ack_slot_ff) begin
          // acknowledge clock over, move on
          ack_slot_ff <= 1'b0;
          ack_drv_ff <= 1'b0;
          bit_ff <= 4'h0;
          // pick the next phase, or ignore the rest of the frame
          if (nak_ff) begin
            state_ff <= ST_SKIP;
          end else if (state_ff == ST_ADDR) begin
            state_ff <= ST_CMD;
          end else if (state_ff == ST_CMD && cnt_ff == `CMD_BYTES) begin
            state_ff <= ST_DATA;
            cnt_ff <= 3'h0;
          end else if (state_ff == ST_DATA && cnt_ff == `DATA_BYTES) begin
            full_ff <= 1'b1;
          end
        end
      end
    end
  end

  // issue the register write once the fourth byte's ack has finished
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // no write pending after reset
      WR_STB <= 1'b0;
      WR_PORT <= 5'h00;
      WR_ADDR <= 12'h000;
      WR_BE <= 4'h0;
      WR_DATA <= 32'h00000000;
    end else if (CE) begin
      // strobe stands for one enabled cycle only
      WR_STB <= 1'b0;
      if (scl_fall && ack_slot_ff && !nak_ff && !start_ev && !stop_ev
          && state_ff == ST_DATA && cnt_ff == `DATA_BYTES && !full_ff
          && cmd_ok) begin
        // hand the whole decoded write over at once
        WR_STB <= 1'b1;
        WR_PORT <= port_sel;
        WR_BE <= cmd2_ff[`BE_LSB+3:`BE_LSB];
        WR_ADDR <= {cmd2_ff[`ADDR_HI_LSB+1:`ADDR_HI_LSB], cmd3_ff,
          2'h0};
        WR_DATA <= data_ff;
      end
    end
  end

  // open drain: the pin is only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_drv_ff;
endmodule // cfg_wr_target
`default_nettype wire

//--- sim/cfg_wr_ctrl_model.sv
// two-wire controller model that issues configuration write frames
// assumes: link clock made here from clk; data line pulled up
`default_nettype none
module cfg_wr_ctrl_model (
  input wire logic clk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_low = 1'b0; // controller pulls data low
  // open drain: either party pulls low, else pull-up wins
  assign sda = !(drv_low || dev_oe);
  initial scl = 1'b1;
  // wait n system clocks, then step off the edge
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one link clock: data set while low, sampled while high
  task automatic bit_x(input logic b, output logic r);
    drv_low = !b;
    q(2);
    scl = 1'b1;
    q(2);
    r = sda;
    q(2);
    scl = 1'b0;
    q(2);
  endtask
  // whole frame: start, bytes with ack slots, stop
  task automatic frame(input logic [7:0] b[$], output logic [15:0] acks);
    logic r;
    acks = 16'h0;
    drv_low = 1'b0;
    q(2);
    scl = 1'b1;
    q(2);
    drv_low = 1'b1;
    q(2);
    scl = 1'b0;
    q(2);
    foreach (b[k]) begin
      for (int i = 7; i >= 0; i--) bit_x(b[k][i], r);
      bit_x(1'b1, r);
      acks = {acks[14:0], !r};
    end
    drv_low = 1'b1;
    q(2);
    scl = 1'b1;
    q(2);
    drv_low = 1'b0;
    q(4);
  endtask
endmodule // cfg_wr_ctrl_model
`default_nettype wire

//--- sim/cfg_wr_target_monitor.sv
// checker for the configuration write target's ports
// assumes: bound into cfg_wr_target, single clock domain
`default_nettype none
module cfg_wr_target_monitor (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic WR_STB,
  input wire logic [4:0] WR_PORT,
  input wire logic [11:0] WR_ADDR,
  input wire logic [3:0] WR_BE,
  input wire logic [31:0] WR_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic [3:0] since_oe_ff; // cycles since ack drive last seen
  // saturating age of the last ack drive
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) since_oe_ff <= 4'hF;
    else if (SDA_OE) since_oe_ff <= 4'h0;
    else if (since_oe_ff != 4'hF) since_oe_ff <= since_oe_ff + 4'h1;
  end
  sequence s_ack_held;
    SDA_OE [*6];
  endsequence
  sequence s_ack_gone;
    ##[1:12] !SDA_OE;
  endsequence
  a_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("data output not low");
  a_ack_stands: assert property ($rose(SDA_OE) |-> s_ack_held)
    else $error("ack dropped early");
  a_ack_ends: assert property (SDA_OE |-> s_ack_gone)
    else $error("ack held too long");
  a_addr_dword: assert property (WR_STB |-> WR_ADDR[1:0] == 2'h0)
    else $error("write address not dword aligned");
  a_port_valid: assert property (WR_STB |-> WR_PORT <= 5'h05)
    else $error("write to port above five");
  a_one_write: assert property (WR_STB |=> !WR_STB [*8])
    else $error("write strobe repeated");
  a_after_ack: assert property (WR_STB |-> since_oe_ff <= 4'h6)
    else $error("write not right after ack");
  a_fields_hold: assert property (!WR_STB |->
    $stable({WR_PORT, WR_ADDR, WR_BE, WR_DATA}))
    else $error("write fields moved without strobe");
endmodule // cfg_wr_target_monitor
bind cfg_wr_target cfg_wr_target_monitor u_mon (.SYS_CLK(SYS_CLK),
  .RESETN(RESETN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WR_STB(WR_STB),
  .WR_PORT(WR_PORT), .WR_ADDR(WR_ADDR), .WR_BE(WR_BE), .WR_DATA(WR_DATA));
`default_nettype wire

//--- sim/cfg_wr_target_tb_top.sv
// bench for the two-wire configuration write target
// assumes: controller model on the link, checker bound in
`default_nettype none
module cfg_wr_target_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr_sel = 3'h0;
  wire scl, sda, oe, sda_out, stb;
  wire [4:0] port;
  wire [11:0] addr;
  wire [3:0] be;
  wire [31:0] data;
  int n_errors = 0;
  int checked = 0;
  int n_stb = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  cfg_wr_target u_cfg_wr_target (.SYS_CLK(clk), .RESETN(resetn), .CE(1'b1),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(oe),
    .ADDR_SEL(addr_sel), .WR_STB(stb), .WR_PORT(port), .WR_ADDR(addr),
    .WR_BE(be), .WR_DATA(data));
  cfg_wr_ctrl_model u_cfg_wr_ctrl_model (.clk(clk), .dev_oe(oe), .scl(scl),
    .sda(sda));
  // count write pulses and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (stb === 1'b1) n_stb++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reference write frame with default straps
  task automatic t_walk();
    logic [15:0] ak;
    int s = n_stb;
    u_cfg_wr_ctrl_model.frame('{8'hD0, 8'h03, 8'h00, 8'h3C, 8'h3E, 8'h12,
      8'h34, 8'h56, 8'h78}, ak);
    chk(ak, 64'h1FF);
    chk(n_stb - s, 1);
    chk({port, addr, be, data},
      {5'h0, 12'h0F8, 4'hF, 32'h12345678});
  endtask
  // port 5, top address, sparse enables, one byte too many
  task automatic t_edge();
    logic [15:0] ak;
    int s = n_stb;
    @(posedge clk) #1 addr_sel = 3'h5;
    u_cfg_wr_ctrl_model.frame('{8'hDA, 8'h03, 8'h02, 8'h97, 8'hFF, 8'hAA,
      8'hBB, 8'hCC, 8'hDD, 8'hEE}, ak);
    chk(ak, 64'h3FE);
    chk(n_stb - s, 1);
    chk({port, addr, be, data},
      {5'h5, 12'hFFC, 4'h5, 32'hAABBCCDD});
  endtask
  // bad opcode, bad port, foreign address, read bit
  task automatic t_refuse();
    logic [15:0] ak;
    int s = n_stb;
    @(posedge clk) #1 addr_sel = 3'h0;
    u_cfg_wr_ctrl_model.frame('{8'hD0, 8'h04, 8'h00, 8'h3C, 8'h00, 8'h01,
      8'h02, 8'h03, 8'h04}, ak);
    chk(ak, 64'h1FF);
    u_cfg_wr_ctrl_model.frame('{8'hD0, 8'h03, 8'h03, 8'h3C, 8'h00, 8'h01,
      8'h02, 8'h03, 8'h04}, ak);
    chk(ak, 64'h1FF);
    u_cfg_wr_ctrl_model.frame('{8'hD2, 8'h03}, ak);
    chk(ak, 64'h0);
    u_cfg_wr_ctrl_model.frame('{8'hD1, 8'h03}, ak);
    chk(ak, 64'h0);
    chk(n_stb - s, 0);
    chk({port, addr, be, data},
      {5'h5, 12'hFFC, 4'h5, 32'hAABBCCDD});
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_walk();
    t_edge();
    t_refuse();
    wrap_up();
  end
endmodule // cfg_wr_target_tb_top
`default_nettype wire
